// [shared/tgpm_consts.svh]
// register offsets, field positions, reset values and fixed numbers of the port mac
`ifndef TGPM_CONSTS_SVH
`define TGPM_CONSTS_SVH
`define TGPM_ADDR_W 8
`define TGPM_OFF_RST_CTRL 8'h00
`define TGPM_OFF_ENA_CFG 8'h04
`define TGPM_OFF_MODE_CFG 8'h08
`define TGPM_OFF_MAXLEN_CFG 8'h0c
`define TGPM_OFF_NUM_TAGS 8'h10
`define TGPM_OFF_TAG0 8'h14
`define TGPM_OFF_TAG1 8'h18
`define TGPM_OFF_TAG2 8'h1c
`define TGPM_OFF_ADV_CHK 8'h20
`define TGPM_OFF_LFS_CFG 8'h24
`define TGPM_OFF_INTR 8'h28
`define TGPM_OFF_CODING_MASK 8'h2c
`define TGPM_OFF_FEC_MASK 8'h30
`define TGPM_OFF_ENERGY_MASK 8'h34
`define TGPM_OFF_STICKY 8'h38
`define TGPM_OFF_OSET_STAT 8'h3c
`define TGPM_OFF_OSET_DATA 8'h40
`define TGPM_RST_CTRL_INIT 32'h0000_000f
`define TGPM_SPEED_POS 4
`define TGPM_SPEED_OFF 3'h6
`define TGPM_SPEED_10G 3'h7
`define TGPM_MAXLEN_INIT 16'h05ee
`define TGPM_MAXLEN_MAX 16'h36b0
`define TGPM_TAG_POS 16
`define TGPM_TAG_BYTES 16'h0004
`define TGPM_VLAN_C 16'h8100
`define TGPM_VLAN_S 16'h88a8
`define TGPM_TAG_INIT 16'h8100
`define TGPM_NUM_TAGS_INIT 2'h3
`define TGPM_LFS_INIT 32'h0000_0001
`define TGPM_FCS_BYTES 16'h0004
`define TGPM_OSET_LOCAL 8'h01
`define TGPM_OSET_REMOTE 8'h02
`endif

// [shared/tgpm_pkg.sv]
// types shared by the port mac
package tgpm_pkg;
  typedef struct packed {
    logic sop;
    logic eop;
    logic [7:0] data;
  } tgpm_byte_t;
  typedef struct packed {
    logic local_fault;
    logic remote_fault;
    logic lock_change;
    logic hi_ber;
    logic [3:0] fec_event;
    logic tx_lpi;
    logic rx_lpi;
    logic link_up;
  } tgpm_pcs_stat_t;
  typedef enum logic [1:0] {
    TGPM_SEQ_NONE,
    TGPM_SEQ_LOCAL,
    TGPM_SEQ_REMOTE
  } tgpm_seq_t;
  typedef enum {
    TGPM_RX_IDLE,
    TGPM_RX_FRAME,
    TGPM_RX_DROP
  } tgpm_rx_state_t;
endpackage

// [hdl/tgpm_port_mac.sv]
// 10g port mac: resets, enables, length checks, fault signalling, event flags
// Summary of operation
// - full duplex, single 10.3125G 64b/66b lane
// - all four resets active after power-up
// - four resets set together in one write
// - five port interrupt indications raised
// - sticky events recorded regardless of mask; mask gates only the irq
// - coding, fec, energy masks feed coding irq
// - speed 6 stops clocks, 7 selects 10g
// - separate receive and transmit enables
// - pause passthrough forwards received pause frames
// - preamble, gap formats and checksum check settings
// - up to 14000 bytes, programmable limit
// - limit grows 4/8/12 for 1/2/3 tags
// - bit selects whether tags extend limit
// - tag count programmable, 8100/88a8 default tags
// - three programmable custom tag ethertypes
// - overlong frame truncated and marked aborted
// - drop in-range and out-of-range length errors
// - optional start, end, delimiter, preamble checks
// - detect faults, send remote sequence set on local fault only
// - one-way mode keeps sending frames under fault
// - fault sets flag, captured in ordered-set fifo
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "tgpm_consts.svh"
module tgpm_port_mac import tgpm_pkg::*; #(
  parameter int OSET_DEPTH = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // register port
  input wire logic [`TGPM_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // receive bytes from coding layer
  input wire tgpm_byte_t rx_in,
  input wire logic rx_in_valid,
  input wire logic rx_is_pause,
  input wire logic rx_len_inrange_err,
  input wire logic rx_len_outrange_err,
  input wire logic rx_check_err,
  // receive bytes to switch core
  output tgpm_byte_t rx_out,
  output logic rx_out_valid,
  output logic rx_out_abort,
  // transmit side
  input wire logic tx_frame_busy,
  output logic tx_gate,
  output tgpm_seq_t tx_seq,
  // coding layer status
  input wire tgpm_pcs_stat_t pcs_stat,
  // resets and clocks toward the lanes
  output logic mac_receive_reset,
  output logic mac_transmit_reset,
  output logic coding_receive_reset,
  output logic coding_transmit_reset,
  output logic lane_clk_enable,
  // port interrupt indications
  output logic coding_layer_irq,
  output logic transmit_idle_change_irq,
  output logic receive_idle_change_irq,
  output logic link_rise_irq,
  output logic link_fall_irq
);
  logic [31:0] rst_ctrl;
  logic receive_path_enable;
  logic transmit_path_enable;
  logic pause_passthrough;
  logic [1:0] preamble_format;
  logic [1:0] gap_format;
  logic header_checksum_check;
  logic [15:0] frame_length_limit;
  logic limit_counts_tags;
  logic [1:0] tag_count_cfg;
  logic [15:0] custom_tag_ethertype [3];
  logic inrange_drop_enable;
  logic outrange_drop_enable;
  logic extended_end_check;
  logic extended_start_check;
  logic delimiter_check;
  logic shrink_check_disable;
  logic preamble_check;
  logic fault_signalling_enable;
  logic one_way_enable;
  logic [3:0] coding_sticky_mask;
  logic [3:0] fec_sticky_mask;
  logic [1:0] energy_sticky_mask;
  logic [3:0] coding_sticky;
  logic [3:0] fec_sticky;
  logic [1:0] energy_sticky;
  logic [7:0] oset_mem [OSET_DEPTH];
  logic [$clog2(OSET_DEPTH):0] oset_count;
  logic [$clog2(OSET_DEPTH)-1:0] oset_wp;
  logic [$clog2(OSET_DEPTH)-1:0] oset_rp;
  tgpm_pcs_stat_t stat_q;
  tgpm_rx_state_t rx_state;
  logic [15:0] rx_len;
  logic [1:0] rx_tags;
  logic [15:0] rx_eth;
  logic rx_eth_hi;
  logic [15:0] eff_limit;
  logic [2:0] speed_sel;
  logic wr_hit;
  logic [31:0] next_rdata;
  logic fault_event;
  logic oset_pop;
  logic check_any;

  function automatic logic is_tag(input logic [15:0] et);
    is_tag = (et == `TGPM_VLAN_C) || (et == `TGPM_VLAN_S) ||
      (et == custom_tag_ethertype[0]) || (et == custom_tag_ethertype[1]) ||
      (et == custom_tag_ethertype[2]);
  endfunction

  assign wr_hit = reg_wr;
  assign speed_sel = rst_ctrl[`TGPM_SPEED_POS+2:`TGPM_SPEED_POS];
  assign mac_receive_reset = rst_ctrl[0];
  assign mac_transmit_reset = rst_ctrl[1];
  assign coding_receive_reset = rst_ctrl[2];
  assign coding_transmit_reset = rst_ctrl[3];
  // reserved speed codes leave the clocks stopped as the safe choice
  assign lane_clk_enable = (speed_sel == `TGPM_SPEED_10G);

  // reset/speed control: all four resets in one word
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rst_ctrl <= `TGPM_RST_CTRL_INIT | (32'(`TGPM_SPEED_10G) << `TGPM_SPEED_POS);
    end else if (wr_hit && reg_addr == `TGPM_OFF_RST_CTRL) begin
      rst_ctrl <= {25'h000_0000, reg_wdata[6:0]};
    end
  end

  // configuration registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      receive_path_enable <= 1'b0;
      transmit_path_enable <= 1'b0;
      pause_passthrough <= 1'b0;
      preamble_format <= 2'h0;
      gap_format <= 2'h0;
      header_checksum_check <= 1'b0;
      frame_length_limit <= `TGPM_MAXLEN_INIT;
      limit_counts_tags <= 1'b1;
      tag_count_cfg <= `TGPM_NUM_TAGS_INIT;
      custom_tag_ethertype[0] <= `TGPM_TAG_INIT;
      custom_tag_ethertype[1] <= `TGPM_TAG_INIT;
      custom_tag_ethertype[2] <= `TGPM_TAG_INIT;
      {preamble_check, shrink_check_disable, delimiter_check} <= 3'h0;
      {extended_start_check, extended_end_check} <= 2'h0;
      {outrange_drop_enable, inrange_drop_enable} <= 2'h0;
      fault_signalling_enable <= 1'b1;
      one_way_enable <= 1'b0;
      coding_sticky_mask <= 4'h0;
      fec_sticky_mask <= 4'h0;
      energy_sticky_mask <= 2'h0;
    end else if (wr_hit) begin
      case (reg_addr)
        `TGPM_OFF_ENA_CFG: begin
          receive_path_enable <= reg_wdata[0];
          transmit_path_enable <= reg_wdata[1];
        end
        `TGPM_OFF_MODE_CFG: begin
          pause_passthrough <= reg_wdata[0];
          preamble_format <= reg_wdata[5:4];
          gap_format <= reg_wdata[9:8];
          header_checksum_check <= reg_wdata[12];
        end
        `TGPM_OFF_MAXLEN_CFG: begin
          // clamp to what the frame buffer can hold
          frame_length_limit <= (reg_wdata[15:0] > `TGPM_MAXLEN_MAX) ?
            `TGPM_MAXLEN_MAX : reg_wdata[15:0];
          limit_counts_tags <= reg_wdata[`TGPM_TAG_POS];
        end
        `TGPM_OFF_NUM_TAGS: tag_count_cfg <= reg_wdata[1:0];
        `TGPM_OFF_TAG0: custom_tag_ethertype[0] <= reg_wdata[15:0];
        `TGPM_OFF_TAG1: custom_tag_ethertype[1] <= reg_wdata[15:0];
        `TGPM_OFF_TAG2: custom_tag_ethertype[2] <= reg_wdata[15:0];
        `TGPM_OFF_ADV_CHK: begin
          inrange_drop_enable <= reg_wdata[0];
          outrange_drop_enable <= reg_wdata[1];
          extended_end_check <= reg_wdata[2];
          extended_start_check <= reg_wdata[3];
          delimiter_check <= reg_wdata[4];
          shrink_check_disable <= reg_wdata[5];
          preamble_check <= reg_wdata[6];
        end
        `TGPM_OFF_LFS_CFG: begin
          fault_signalling_enable <= reg_wdata[0];
          one_way_enable <= reg_wdata[1];
        end
        `TGPM_OFF_CODING_MASK: coding_sticky_mask <= reg_wdata[3:0];
        `TGPM_OFF_FEC_MASK: fec_sticky_mask <= reg_wdata[3:0];
        `TGPM_OFF_ENERGY_MASK: energy_sticky_mask <= reg_wdata[1:0];
        default: ;
      endcase
    end
  end

  // sticky flags: set wins over write-one-to-clear
  assign fault_event = (pcs_stat.local_fault && !stat_q.local_fault) ||
    (pcs_stat.remote_fault && !stat_q.remote_fault);
  always_ff @(posedge core_clk) begin
    if (srst) begin
      stat_q <= '0;
      coding_sticky <= 4'h0;
      fec_sticky <= 4'h0;
      energy_sticky <= 2'h0;
    end else begin
      stat_q <= pcs_stat;
      coding_sticky <= (coding_sticky &
        ~((wr_hit && reg_addr == `TGPM_OFF_STICKY) ? reg_wdata[3:0] : 4'h0)) |
        {fault_event, pcs_stat.lock_change, pcs_stat.hi_ber,
         pcs_stat.link_up != stat_q.link_up};
      fec_sticky <= (fec_sticky &
        ~((wr_hit && reg_addr == `TGPM_OFF_STICKY) ? reg_wdata[11:8] : 4'h0)) |
        pcs_stat.fec_event;
      energy_sticky <= (energy_sticky &
        ~((wr_hit && reg_addr == `TGPM_OFF_STICKY) ? reg_wdata[17:16] : 2'h0)) |
        {pcs_stat.tx_lpi != stat_q.tx_lpi, pcs_stat.rx_lpi != stat_q.rx_lpi};
    end
  end

  // interrupt indications are levels; the chip controller latches them
  assign coding_layer_irq = |(coding_sticky & coding_sticky_mask) ||
    |(fec_sticky & fec_sticky_mask) ||
    |(energy_sticky & energy_sticky_mask);
  assign transmit_idle_change_irq = energy_sticky[1];
  assign receive_idle_change_irq = energy_sticky[0];
  assign link_rise_irq = stat_q.link_up;
  assign link_fall_irq = !stat_q.link_up;

  // ordered-set capture fifo; a full fifo keeps the oldest entries
  assign oset_pop = reg_rd && reg_addr == `TGPM_OFF_OSET_DATA && oset_count != '0;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      oset_count <= '0;
      oset_wp <= '0;
      oset_rp <= '0;
    end else begin
      if (fault_event && oset_count != ($clog2(OSET_DEPTH)+1)'(OSET_DEPTH)) begin
        oset_mem[oset_wp] <= pcs_stat.local_fault ? `TGPM_OSET_LOCAL
          : `TGPM_OSET_REMOTE;
        oset_wp <= oset_wp + 1'b1;
      end
      if (oset_pop) begin
        oset_rp <= oset_rp + 1'b1;
      end
      oset_count <= oset_count +
        ((fault_event && oset_count != ($clog2(OSET_DEPTH)+1)'(OSET_DEPTH)) ? 1'b1 : 1'b0) -
        (oset_pop ? 1'b1 : 1'b0);
    end
  end

  // transmit fault response
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tx_seq <= TGPM_SEQ_NONE;
      tx_gate <= 1'b0;
    end else begin
      if (!fault_signalling_enable) begin
        tx_seq <= TGPM_SEQ_NONE;
      end else if (stat_q.local_fault) begin
        tx_seq <= TGPM_SEQ_REMOTE;
      end else if (stat_q.remote_fault) begin
        tx_seq <= TGPM_SEQ_NONE;
      end else begin
        tx_seq <= TGPM_SEQ_NONE;
      end
      // frames stop under fault unless one-way mode, a busy frame or disabled fault signalling keeps the gate open
      tx_gate <= transmit_path_enable && !mac_transmit_reset && lane_clk_enable &&
        (!fault_signalling_enable || one_way_enable || tx_frame_busy ||
         !(stat_q.local_fault || stat_q.remote_fault));
    end
  end

  // receive length check and forwarding
  assign eff_limit = frame_length_limit +
    (limit_counts_tags ? 16'(rx_tags) * `TGPM_TAG_BYTES : 16'h0000);
  assign check_any = rx_check_err && (extended_end_check || extended_start_check ||
    delimiter_check || preamble_check || !shrink_check_disable);
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rx_state <= TGPM_RX_IDLE;
      rx_len <= 16'h0000;
      rx_tags <= 2'h0;
      rx_eth <= 16'h0000;
      rx_eth_hi <= 1'b0;
      rx_out <= '0;
      rx_out_valid <= 1'b0;
      rx_out_abort <= 1'b0;
    end else begin
      rx_out_valid <= 1'b0;
      rx_out_abort <= 1'b0;
      if (rx_in_valid && receive_path_enable && !mac_receive_reset && lane_clk_enable) begin
        rx_out <= rx_in;
        // the first byte seen is the first destination address byte
        rx_len <= rx_in.sop ? 16'h0001 : rx_len + 16'h0001;
        if (rx_in.sop) begin
          rx_tags <= 2'h0;
        end
        // tag ethertype sits at bytes 13-14, then each 4 bytes after a tag
        if (rx_len == 16'd12 + 16'(rx_tags) * `TGPM_TAG_BYTES) begin
          rx_eth[15:8] <= rx_in.data;
          rx_eth_hi <= 1'b1;
        end else if (rx_eth_hi) begin
          rx_eth_hi <= 1'b0;
          if (is_tag({rx_eth[15:8], rx_in.data}) && rx_tags < tag_count_cfg) begin
            rx_tags <= rx_tags + 2'h1;
          end
        end
        case (rx_state)
          TGPM_RX_IDLE: begin
            if (rx_in.sop && !(rx_is_pause && !pause_passthrough)) begin
              rx_out_valid <= 1'b1;
              rx_state <= rx_in.eop ? TGPM_RX_IDLE : TGPM_RX_FRAME;
            end else if (rx_in.sop && !rx_in.eop) begin
              rx_state <= TGPM_RX_DROP;
            end
          end
          TGPM_RX_FRAME: begin
            // the byte that fills the limit closes a longer frame, so output never exceeds it
            if (!rx_in.sop && !rx_in.eop && rx_len + 16'h0001 >= eff_limit) begin
              rx_out.eop <= 1'b1;
              rx_out_valid <= 1'b1;
              rx_out_abort <= 1'b1;
              rx_state <= rx_in.eop ? TGPM_RX_IDLE : TGPM_RX_DROP;
            end else begin
              rx_out_valid <= 1'b1;
              if (rx_in.eop) begin
                rx_out_abort <= (inrange_drop_enable && rx_len_inrange_err) ||
                  (outrange_drop_enable && rx_len_outrange_err) || check_any;
                rx_state <= TGPM_RX_IDLE;
              end
            end
          end
          TGPM_RX_DROP: begin
            if (rx_in.eop) begin
              rx_state <= TGPM_RX_IDLE;
            end
          end
          default: rx_state <= TGPM_RX_IDLE;
        endcase
      end
    end
  end

  // register read, data one cycle after the strobe
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (reg_addr)
      `TGPM_OFF_RST_CTRL: next_rdata = rst_ctrl;
      `TGPM_OFF_ENA_CFG: next_rdata = {30'h0, transmit_path_enable, receive_path_enable};
      `TGPM_OFF_MODE_CFG: next_rdata = {19'h0, header_checksum_check, 2'h0, gap_format,
        2'h0, preamble_format, 3'h0, pause_passthrough};
      `TGPM_OFF_MAXLEN_CFG: next_rdata = {15'h0, limit_counts_tags, frame_length_limit};
      `TGPM_OFF_NUM_TAGS: next_rdata = {30'h0, tag_count_cfg};
      `TGPM_OFF_TAG0: next_rdata = {16'h0, custom_tag_ethertype[0]};
      `TGPM_OFF_TAG1: next_rdata = {16'h0, custom_tag_ethertype[1]};
      `TGPM_OFF_TAG2: next_rdata = {16'h0, custom_tag_ethertype[2]};
      `TGPM_OFF_ADV_CHK: next_rdata = {25'h0, preamble_check, shrink_check_disable,
        delimiter_check, extended_start_check, extended_end_check,
        outrange_drop_enable, inrange_drop_enable};
      `TGPM_OFF_LFS_CFG: next_rdata = {30'h0, one_way_enable, fault_signalling_enable};
      `TGPM_OFF_INTR: next_rdata = {27'h0, link_fall_irq, link_rise_irq,
        receive_idle_change_irq, transmit_idle_change_irq, coding_layer_irq};
      `TGPM_OFF_CODING_MASK: next_rdata = {28'h0, coding_sticky_mask};
      `TGPM_OFF_FEC_MASK: next_rdata = {28'h0, fec_sticky_mask};
      `TGPM_OFF_ENERGY_MASK: next_rdata = {30'h0, energy_sticky_mask};
      `TGPM_OFF_STICKY: next_rdata = {14'h0, energy_sticky, 4'h0, fec_sticky,
        4'h0, coding_sticky};
      `TGPM_OFF_OSET_STAT: next_rdata = 32'(oset_count);
      `TGPM_OFF_OSET_DATA: next_rdata = (oset_count != '0) ?
        {24'h0, oset_mem[oset_rp]} : 32'h0000_0000;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : 32'h0000_0000;
    end
  end
endmodule

// [sim/tgpm_port_mac_sva.sv]
// concurrent checks on the port mac register, receive and status ports
`timescale 1ns/1ps
`include "tgpm_consts.svh"
module tgpm_port_mac_sva import tgpm_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // register port
  input wire logic [`TGPM_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // receive stream
  input wire tgpm_byte_t rx_in,
  input wire logic rx_in_valid,
  input wire tgpm_byte_t rx_out,
  input wire logic rx_out_valid,
  input wire logic rx_out_abort,
  // status and lane controls
  input wire tgpm_pcs_stat_t pcs_stat,
  input wire logic mac_receive_reset,
  input wire logic mac_transmit_reset,
  input wire logic coding_receive_reset,
  input wire logic coding_transmit_reset,
  input wire logic lane_clk_enable,
  input wire logic link_rise_irq,
  input wire logic link_fall_irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic rst_wr;
  logic [3:0] rst_out;
  assign rst_wr = reg_wr && reg_addr == `TGPM_OFF_RST_CTRL;
  assign rst_out = {coding_transmit_reset, coding_receive_reset, mac_transmit_reset,
                    mac_receive_reset};
  property p_rst_bits;
    rst_wr |=> rst_out == $past(reg_wdata[3:0]);
  endproperty
  a_rst_bits: assert property (p_rst_bits) else $error("reset outputs differ from write");
  property p_rst_hold;
    mac_receive_reset && !rst_wr |=> mac_receive_reset;
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("receive reset left without write");
  property p_boot;
    $fell(srst) |-> rst_out == 4'hf;
  endproperty
  a_boot: assert property (p_boot) else $error("resets not active after power-up");
  property p_speed;
    rst_wr |=> lane_clk_enable == ($past(reg_wdata[6:4]) == `TGPM_SPEED_10G);
  endproperty
  a_speed: assert property (p_speed) else $error("lane clock enable wrong for speed");
  property p_rd_idle;
    !reg_rd |=> reg_rdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without a read");
  property p_rx_pipe;
    rx_out_valid |-> $past(rx_in_valid) && rx_out.data == $past(rx_in.data);
  endproperty
  a_rx_pipe: assert property (p_rx_pipe) else $error("receive byte not passed on");
  property p_rx_gated;
    mac_receive_reset || !lane_clk_enable |=> !rx_out_valid;
  endproperty
  a_rx_gated: assert property (p_rx_gated) else $error("receive byte while held off");
  property p_abort;
    rx_out_abort |-> rx_out_valid && rx_out.eop;
  endproperty
  a_abort: assert property (p_abort) else $error("abort without closing byte");
  property p_link;
    pcs_stat.link_up |=> link_rise_irq && !link_fall_irq;
  endproperty
  a_link: assert property (p_link) else $error("link indications wrong");
  c_abort: cover property (rx_out_abort);
  c_rst_cycle: cover property (rst_wr ##2 rst_wr);
  c_link: cover property ($rose(link_rise_irq));
endmodule
bind tgpm_port_mac tgpm_port_mac_sva u_sva (.*);

// [sim/tgpm_pcs_model.sv]
// coding layer model: feeds receive frames and status toward the mac
`timescale 1ns/1ps
module tgpm_pcs_model import tgpm_pkg::*; (
  // clock
  input wire logic core_clk,
  // receive stream toward the mac
  output tgpm_byte_t rx_in,
  output logic rx_in_valid,
  output logic rx_is_pause,
  // coding layer status
  output tgpm_pcs_stat_t pcs_stat
);
  initial begin
    rx_in = '0;
    rx_in_valid = 1'b0;
    rx_is_pause = 1'b0;
    pcs_stat = '0;
  end
  task automatic set_stat(input tgpm_pcs_stat_t s);
    @(posedge core_clk);
    pcs_stat <= s;
  endtask
  // len runs from first address byte through last fcs byte
  task automatic send(input int len, input int ntag, input logic [15:0] tpid, input bit pause,
                      input int gap);
    logic [7:0] b;
    for (int i = 0; i < len; i++) begin
      b = 8'(i);
      if (i >= 12 && i < 12 + 4 * ntag && (i - 12) % 4 < 2) begin
        b = ((i - 12) % 4 == 0) ? tpid[15:8] : tpid[7:0];
      end
      @(posedge core_clk);
      rx_in <= '{sop: i == 0, eop: i == len - 1, data: b};
      rx_in_valid <= 1'b1;
      rx_is_pause <= pause;
      // slow source: gap cycles show flipped data; the idle after a gapped frame shows its last byte again
      repeat (gap) begin
        @(posedge core_clk);
        rx_in_valid <= 1'b0;
        rx_in.data <= ~b;
      end
    end
    @(posedge core_clk);
    rx_in_valid <= 1'b0;
    rx_in.data <= ~rx_in.data;
  endtask
endmodule

// [sim/tb_top.sv]
// self-checking bench for the port mac
`timescale 1ns/1ps
`include "tgpm_consts.svh"
module tb_top import tgpm_pkg::*; ();
  logic core_clk, srst, reg_wr, reg_rd, tx_frame_busy, tx_gate;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_val;
  logic rx_in_valid, rx_is_pause, rx_out_valid, rx_out_abort, rx_check_err;
  logic rx_len_inrange_err, rx_len_outrange_err;
  tgpm_byte_t rx_in, rx_out;
  tgpm_seq_t tx_seq;
  tgpm_pcs_stat_t pcs_stat, s;
  logic mac_receive_reset, mac_transmit_reset, coding_receive_reset, coding_transmit_reset;
  logic lane_clk_enable, coding_layer_irq, transmit_idle_change_irq, receive_idle_change_irq;
  logic link_rise_irq, link_fall_irq;
  int mismatches, n_tests, cycles, n_out, n_abort;
  tgpm_port_mac dut (.*);
  tgpm_pcs_model pcs (.*);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles = cycles + 1;
    if (rx_out_valid === 1'b1) n_out = n_out + 1;
    if (rx_out_abort === 1'b1) n_abort = n_abort + 1;
    // whole run needs well under this many cycles
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end
  task automatic test_done();
    if (mismatches == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  // config write followed by the reset pulse software owes the port
  task automatic cfg(input logic [7:0] a, input logic [31:0] d);
    wr(a, d);
    wr(`TGPM_OFF_RST_CTRL, 32'h0000_007f);
    wr(`TGPM_OFF_RST_CTRL, 32'h0000_0070);
  endtask
  task automatic frame(input int len, input int ntag, input logic [15:0] tpid, input bit pause,
                       input int gap);
    n_out = 0;
    n_abort = 0;
    pcs.send(len, ntag, tpid, pause, gap);
    repeat (3) @(posedge core_clk);
  endtask
  task automatic t_reset();
    chk("resets", {28'h0, coding_transmit_reset, coding_receive_reset, mac_transmit_reset,
        mac_receive_reset}, 32'h0000_000f);
    chk("fall", {31'h0, link_fall_irq}, 32'h0000_0001);
    rd(`TGPM_OFF_MAXLEN_CFG);
    chk("maxlen", {16'h0, rd_val[15:0]}, 32'h0000_05ee);
    rd(`TGPM_OFF_NUM_TAGS);
    chk("ntags", {30'h0, rd_val[1:0]}, 32'h0000_0003);
    rd(`TGPM_OFF_TAG0);
    chk("tag0", {16'h0, rd_val[15:0]}, 32'h0000_8100);
    rd(`TGPM_OFF_LFS_CFG);
    chk("lfs", {31'h0, rd_val[0]}, 32'h0000_0001);
    rd(8'hfc);
    chk("unmapped", rd_val, 32'h0000_0000);
  endtask
  task automatic t_ctrl();
    wr(`TGPM_OFF_RST_CTRL, 32'h0000_0070);
    #1 chk("rel", {31'h0, mac_receive_reset | coding_transmit_reset}, 32'h0);
    wr(`TGPM_OFF_RST_CTRL, 32'h0000_0060);
    #1 chk("clkoff", {31'h0, lane_clk_enable}, 32'h0);
    wr(`TGPM_OFF_ENA_CFG, 32'hffff_ffff);
    frame(20, 0, 16'h0000, 1'b0, 0);
    chk("stopped", n_out, 32'h0);
    cfg(`TGPM_OFF_ENA_CFG, 32'h0000_0000);
    frame(20, 0, 16'h0000, 1'b0, 0);
    chk("disabled", n_out, 32'h0);
    cfg(`TGPM_OFF_ENA_CFG, 32'hffff_ffff);
    frame(20, 0, 16'h0000, 1'b0, 2);
    chk("enabled", n_out, 32'd20);
  endtask
  task automatic t_len();
    cfg(`TGPM_OFF_MAXLEN_CFG, 32'h0000_0040);
    frame(64, 0, 16'h0000, 1'b0, 0);
    chk("atlimit", {n_out[15:0], n_abort[15:0]}, {16'd64, 16'd0});
    frame(70, 0, 16'h0000, 1'b0, 0);
    chk("cut", {n_out[15:0], n_abort[15:0]}, {16'd64, 16'd1});
    frame(68, 1, `TGPM_VLAN_C, 1'b0, 0);
    chk("notagchk", n_abort, 32'h1);
    cfg(`TGPM_OFF_MAXLEN_CFG, 32'h0001_0040);
    frame(68, 1, `TGPM_VLAN_C, 1'b0, 0);
    chk("onetag", {n_out[15:0], n_abort[15:0]}, {16'd68, 16'd0});
    frame(69, 1, `TGPM_VLAN_C, 1'b0, 0);
    chk("onetag+1", n_abort, 32'h1);
    frame(72, 2, `TGPM_VLAN_S, 1'b0, 0);
    chk("twotag", n_abort, 32'h0);
    cfg(`TGPM_OFF_TAG0, 32'h0000_9100);
    frame(68, 1, 16'h9100, 1'b0, 0);
    chk("custom", n_abort, 32'h0);
    wr(`TGPM_OFF_MAXLEN_CFG, 32'h0000_ffff);
    rd(`TGPM_OFF_MAXLEN_CFG);
    chk("clamp", {16'h0, rd_val[15:0]}, {16'h0, `TGPM_MAXLEN_MAX});
    cfg(`TGPM_OFF_MODE_CFG, 32'h0000_0000);
    frame(20, 0, 16'h0000, 1'b1, 0);
    chk("pausedrop", n_out, 32'h0);
    cfg(`TGPM_OFF_MODE_CFG, 32'h0000_0001);
    frame(20, 0, 16'h0000, 1'b1, 0);
    chk("pausepass", n_out, 32'd20);
    rx_len_inrange_err <= 1'b1;
    wr(`TGPM_OFF_ADV_CHK, 32'h0000_0001);
    frame(20, 0, 16'h0000, 1'b0, 0);
    chk("inrange", n_abort, 32'h1);
    {rx_len_inrange_err, rx_check_err} <= 2'b01;
    frame(20, 0, 16'h0000, 1'b0, 0);
    chk("chkerr", n_abort, 32'h1);
    wr(`TGPM_OFF_ADV_CHK, 32'h0000_0020);
    frame(20, 0, 16'h0000, 1'b0, 0);
    chk("chkoff", n_abort, 32'h0);
    rx_check_err <= 1'b0;
  endtask
  task automatic t_irq();
    s = '0;
    s.hi_ber = 1'b1;
    pcs.set_stat(s);
    s = '0;
    pcs.set_stat(s);
    repeat (3) @(posedge core_clk);
    chk("masked", {31'h0, coding_layer_irq}, 32'h0);
    wr(`TGPM_OFF_CODING_MASK, 32'hffff_ffff);
    #1 chk("unmasked", {31'h0, coding_layer_irq}, 32'h1);
    wr(`TGPM_OFF_STICKY, 32'hffff_ffff);
    #1 chk("cleared", {31'h0, coding_layer_irq}, 32'h0);
    wr(`TGPM_OFF_FEC_MASK, 32'hffff_ffff);
    s.fec_event = 4'h1;
    s.tx_lpi = 1'b1;
    s.rx_lpi = 1'b1;
    s.link_up = 1'b1;
    pcs.set_stat(s);
    s.fec_event = 4'h0;
    pcs.set_stat(s);
    repeat (3) @(posedge core_clk);
    chk("fec", {31'h0, coding_layer_irq}, 32'h1);
    chk("lpi", {30'h0, transmit_idle_change_irq, receive_idle_change_irq}, 32'h3);
    chk("link", {30'h0, link_rise_irq, link_fall_irq}, 32'h2);
  endtask
  task automatic t_fault();
    s.local_fault = 1'b1;
    pcs.set_stat(s);
    repeat (4) @(posedge core_clk);
    chk("seq", {30'h0, tx_seq}, {30'h0, TGPM_SEQ_REMOTE});
    chk("gateoff", {31'h0, tx_gate}, 32'h0);
    wr(`TGPM_OFF_LFS_CFG, 32'h0000_0003);
    repeat (2) @(posedge core_clk);
    chk("oneway", {31'h0, tx_gate}, 32'h1);
    rd(`TGPM_OFF_OSET_STAT);
    chk("osetcnt", {31'h0, rd_val != 0}, 32'h1);
    rd(`TGPM_OFF_OSET_DATA);
    chk("osetdata", {24'h0, rd_val[7:0]}, {24'h0, `TGPM_OSET_LOCAL});
    wr(`TGPM_OFF_LFS_CFG, 32'h0000_0000);
    repeat (2) @(posedge core_clk);
    chk("lfsoff", {30'h0, tx_seq}, {30'h0, TGPM_SEQ_NONE});
  endtask
  initial begin
    srst = 1'b1;
    {reg_wr, reg_rd, tx_frame_busy, rx_check_err} = '0;
    {rx_len_inrange_err, rx_len_outrange_err} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    {mismatches, n_tests, cycles, n_out, n_abort} = '0;
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    t_reset();
    t_ctrl();
    t_len();
    t_irq();
    t_fault();
    test_done();
  end
endmodule
